// ===== ssrh_regs.svh
// constants for the serial slave request handler
`ifndef SSRH_REGS_SVH
`define SSRH_REGS_SVH
// function codes
`define SSRH_FC_RD_COIL   8'h01
`define SSRH_FC_RD_DISC   8'h02
`define SSRH_FC_RD_HOLD   8'h03
`define SSRH_FC_RD_INREG  8'h04
`define SSRH_FC_WR_COIL   8'h05
`define SSRH_FC_WR_REG    8'h06
`define SSRH_FC_DIAG      8'h08
`define SSRH_FC_WR_COILS  8'h0F
`define SSRH_FC_WR_REGS   8'h10
// exception codes and flag bit
`define SSRH_EX_FUNC      8'h01
`define SSRH_EX_ADDR      8'h02
`define SSRH_EX_VALUE     8'h03
`define SSRH_EX_FLAG      8'h80
// diagnostic subfunctions
`define SSRH_SUB_ECHO     16'h0000
`define SSRH_SUB_RESTART  16'h0001
`define SSRH_SUB_DIAGREG  16'h0002
`define SSRH_SUB_DELIM    16'h0003
`define SSRH_SUB_LISTEN   16'h0004
// map sizes and request limits (plain counts, first address zero)
`define SSRH_NUM_COILS    16'h0020
`define SSRH_NUM_DISC     16'h0020
`define SSRH_NUM_INREG    16'h0030
`define SSRH_NUM_HOLD     16'h0070
`define SSRH_HOLD_OUT_END 16'h0030
`define SSRH_INT_FULL     16'h2710
`define SSRH_MAX_BITS     16'h07D0
`define SSRH_MAX_REGS     16'h007D
// coil force values
`define SSRH_COIL_ON      16'hFF00
`define SSRH_COIL_OFF     16'h0000
// reset values
`define SSRH_DELIM_RST    8'h0A
`endif

// ===== ssrh_pkg.sv
// types for the serial slave request handler
package ssrh_pkg;
	// decoded request from the framer
	typedef struct packed
	{
		logic [7:0]  func;
		logic [15:0] addr;
		logic [15:0] qty;
		logic [15:0] data;
	} ssrh_req_t;
	// response header to the framer
	typedef struct packed
	{
		logic        exc;
		logic [7:0]  func;
		logic [7:0]  code;
		logic [15:0] addr;
		logic [15:0] data;
	} ssrh_rsp_t;
	typedef enum logic [1:0]
	{
		SSRH_IDLE = 2'b00,
		SSRH_EXEC = 2'b01,
		SSRH_SEND = 2'b11
	} ssrh_state_t;
endpackage

// ===== ssrh_core.sv
// request interpreter for the serial analog I/O slave
`timescale 1ns/1ps
`include "ssrh_regs.svh"

module ssrh_core
(
	// clock and reset
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	// module type strap: 1 input module, 0 output module
	input  wire logic               is_input_i,
	// request from the framer
	input  wire logic               req_valid_i,
	input  wire ssrh_pkg::ssrh_req_t req_i,
	output logic                    req_ready_o,
	// word write data for preset-multiple and force-multiple
	input  wire logic [15:0]        wr_word_i,
	input  wire logic [6:0]         wr_idx_o_unused_i,
	// response to the framer
	output logic                    rsp_valid_o,
	output ssrh_pkg::ssrh_rsp_t     rsp_o,
	input  wire logic               rsp_ready_i,
	// read port for response payload (word index from addr)
	input  wire logic [6:0]         rd_idx_i,
	output logic [15:0]             rd_word_o,
	output logic                    rd_bit_o,
	// analog side status, same clock
	input  wire logic [15:0]        ch_active_i,
	input  wire logic [15:0]        ch_range_err_i,
	input  wire logic [15:0]        ain_int_i [16],
	input  wire logic [31:0]        ain_flt_i [16],
	// configuration outputs
	output logic [31:0]             coils_o,
	output logic [15:0]             hold_o [112],
	output logic [7:0]              delim_o,
	output logic                    listen_only_o,
	output logic                    comm_restart_o,
	// diagnostic register from the framer
	input  wire logic [15:0]        diag_reg_i
);

	// ----------------------------------------
	// state and storage
	// ----------------------------------------
	ssrh_pkg::ssrh_state_t state_r, state_nxt;
	ssrh_pkg::ssrh_req_t   req_r;
	ssrh_pkg::ssrh_rsp_t   rsp_r;
	logic [31:0]           coils_r;
	logic [15:0]           hold_r [112];
	logic [7:0]            delim_r;
	logic                  listen_r;
	logic                  restart_r;
	logic [6:0]            wcnt_r;
	logic [31:0]           disc_w;

	// ----------------------------------------
	// request decode
	// ----------------------------------------
	wire [7:0]  fc = req_r.func;
	wire [16:0] last = {1'b0, req_r.addr} + {1'b0, req_r.qty};
	wire is_rd_coil  = (fc == `SSRH_FC_RD_COIL)  && is_input_i;
	wire is_rd_disc  = (fc == `SSRH_FC_RD_DISC);
	wire is_rd_hold  = (fc == `SSRH_FC_RD_HOLD);
	wire is_rd_inreg = (fc == `SSRH_FC_RD_INREG) && is_input_i;
	wire is_wr_coil  = (fc == `SSRH_FC_WR_COIL)  && is_input_i;
	wire is_wr_coils = (fc == `SSRH_FC_WR_COILS) && is_input_i;
	wire is_wr_reg   = (fc == `SSRH_FC_WR_REG);
	wire is_wr_regs  = (fc == `SSRH_FC_WR_REGS);
	wire is_diag     = (fc == `SSRH_FC_DIAG);
	wire diag_ok     = (req_r.addr <= `SSRH_SUB_LISTEN);
	// anything else, code 11 among them, is refused
	wire fc_ok = is_rd_coil | is_rd_disc | is_rd_hold | is_rd_inreg | is_wr_coil
		| is_wr_coils | is_wr_reg | is_wr_regs | (is_diag & diag_ok);
	// input module has no int/float output registers below 48: holding reads and writes there are refused
	wire [15:0] lim = is_rd_coil | is_wr_coil | is_wr_coils ? `SSRH_NUM_COILS :
		is_rd_disc ? `SSRH_NUM_DISC : is_rd_inreg ? `SSRH_NUM_INREG : `SSRH_NUM_HOLD;
	wire one = is_wr_coil | is_wr_reg;
	wire hold_lo_bad = (is_rd_hold | is_wr_reg | is_wr_regs) && is_input_i
		&& (req_r.addr < `SSRH_HOLD_OUT_END);
	wire addr_bad = !is_diag && ((one ? ({1'b0, req_r.addr} >= {1'b0, lim})
		: (last > {1'b0, lim})) || hold_lo_bad);
	wire bitfc = is_rd_coil | is_rd_disc | is_wr_coils;
	wire qty_bad = !one && !is_diag && (req_r.qty == 16'h0000
		|| req_r.qty > (bitfc ? `SSRH_MAX_BITS : `SSRH_MAX_REGS));
	wire coil_bad = is_wr_coil && req_r.data != `SSRH_COIL_ON && req_r.data != `SSRH_COIL_OFF;
	wire int_bad = is_wr_reg && req_r.addr < 16'h0010 && req_r.data > `SSRH_INT_FULL;
	wire val_bad = qty_bad | coil_bad | int_bad;
	wire [7:0] exc_code = !fc_ok ? `SSRH_EX_FUNC : addr_bad ? `SSRH_EX_ADDR : `SSRH_EX_VALUE;
	wire exc = !fc_ok | addr_bad | val_bad;
	// a legal listen-only command gets no answer either, not only the ones after it
	wire enter_listen = is_diag && (req_r.addr == `SSRH_SUB_LISTEN) && !exc;

	// ----------------------------------------
	// discrete inputs: active then out-of-range
	// ----------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 16; gi++)
		begin : g_disc
			assign disc_w[gi]      = ch_active_i[gi];
			assign disc_w[gi + 16] = ch_range_err_i[gi];
		end
	endgenerate

	// ----------------------------------------
	// read data path
	// ----------------------------------------
	wire [5:0]  ir = rd_idx_i[5:0];
	wire [15:0] inreg_w = ir < 6'd16 ? ain_int_i[ir[3:0]] :
		(ir < 6'd48 ? (ir[0] ? ain_flt_i[4'(ir - 6'd16 >> 1)][15:0]
		: ain_flt_i[4'(ir - 6'd16 >> 1)][31:16]) : 16'h0000);
	wire [15:0] hread_w = rd_idx_i < 7'd112 ? hold_r[rd_idx_i] : 16'h0000;
	always_ff @(posedge clk_i)
	begin
		rd_word_o <= is_rd_inreg ? inreg_w : hread_w;
		rd_bit_o  <= is_rd_disc ? disc_w[rd_idx_i[4:0]] : coils_r[rd_idx_i[4:0]];
	end

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			ssrh_pkg::SSRH_IDLE:
			begin
				if (req_valid_i)
					state_nxt = ssrh_pkg::SSRH_EXEC;
			end
			// no send state in listen-only, nor for the command that enters it
			ssrh_pkg::SSRH_EXEC:
			begin
				if (listen_r || enter_listen)
					state_nxt = ssrh_pkg::SSRH_IDLE;
				else
					state_nxt = ssrh_pkg::SSRH_SEND;
			end
			ssrh_pkg::SSRH_SEND:
			begin
				if (rsp_ready_i)
					state_nxt = ssrh_pkg::SSRH_IDLE;
			end
			default:
				state_nxt = ssrh_pkg::SSRH_IDLE;
		endcase
	end

	// response and side effects
	// writes happen only when the whole request is legal: no partial update
	wire go = (state_r == ssrh_pkg::SSRH_EXEC);
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_r   <= ssrh_pkg::SSRH_IDLE;
			req_r     <= '0;
			rsp_r     <= '0;
			coils_r   <= 32'h00000000;
			delim_r   <= `SSRH_DELIM_RST;
			listen_r  <= 1'b0;
			restart_r <= 1'b0;
		end
		else
		begin
			state_r   <= state_nxt;
			restart_r <= 1'b0;
			if (state_r == ssrh_pkg::SSRH_IDLE && req_valid_i)
				req_r <= req_i;
			if (go)
			begin
				rsp_r.exc  <= exc;
				rsp_r.func <= exc ? (fc | `SSRH_EX_FLAG) : fc;
				rsp_r.code <= exc ? exc_code : 8'h00;
				rsp_r.addr <= req_r.addr;
				rsp_r.data <= (is_diag && req_r.addr == `SSRH_SUB_DIAGREG) ? diag_reg_i : req_r.data;
				if (!exc && is_wr_coil)
					coils_r[req_r.addr[4:0]] <= (req_r.data == `SSRH_COIL_ON);
				if (!exc && is_wr_coils)
					coils_r <= (coils_r & ~(((32'h1 << req_r.qty[5:0]) - 32'h1) << req_r.addr[4:0]))
						| ((32'(wr_word_i) & ((32'h1 << req_r.qty[5:0]) - 32'h1)) << req_r.addr[4:0]);
				if (!exc && is_diag && req_r.addr == `SSRH_SUB_DELIM)
					delim_r <= req_r.data[15:8];
				if (!exc && is_diag && req_r.addr == `SSRH_SUB_LISTEN)
					listen_r <= 1'b1;
				if (!exc && is_diag && req_r.addr == `SSRH_SUB_RESTART)
				begin
					listen_r  <= 1'b0;
					restart_r <= 1'b1;
				end
			end
		end
	end

	// holding registers, one write lane per entry
	generate
		for (gi = 0; gi < 112; gi++)
		begin : g_hold
			always_ff @(posedge clk_i)
			begin
				if (rst_i)
					hold_r[gi] <= 16'h0000;
				else if (go && !exc && ((is_wr_reg && req_r.addr == 16'(gi))
					|| (is_wr_regs && req_r.addr == 16'(gi))))
					hold_r[gi] <= is_wr_reg ? req_r.data : wr_word_i;
			end
			assign hold_o[gi] = hold_r[gi];
		end
	endgenerate

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign req_ready_o    = (state_r == ssrh_pkg::SSRH_IDLE);
	assign rsp_valid_o    = (state_r == ssrh_pkg::SSRH_SEND);  // none in listen-only
	assign rsp_o          = rsp_r;
	assign coils_o        = coils_r;
	assign delim_o        = delim_r;
	assign listen_only_o  = listen_r;
	assign comm_restart_o = restart_r;                         // framer clears counters

	// ----------------------------------------
	// checks
	// ----------------------------------------
	AST_FUNC: assert property (@(posedge clk_i) disable iff (rst_i)
		go && !fc_ok && !listen_r |=> rsp_r.code == `SSRH_EX_FUNC && rsp_valid_o)
		else $error("unsupported function not refused");
	AST_ADDR: assert property (@(posedge clk_i) disable iff (rst_i)
		go && fc_ok && addr_bad |=> rsp_r.code == `SSRH_EX_ADDR)
		else $error("bad address not refused");
	AST_VAL: assert property (@(posedge clk_i) disable iff (rst_i)
		go && fc_ok && !addr_bad && val_bad |=> rsp_r.code == `SSRH_EX_VALUE)
		else $error("bad value not refused");
	AST_EXFC: assert property (@(posedge clk_i) disable iff (rst_i)
		go && exc |=> rsp_r.func == ($past(req_r.func) | 8'h80) && rsp_r.exc)
		else $error("exception function wrong");
	AST_LISTEN: assert property (@(posedge clk_i) disable iff (rst_i)
		listen_r |-> !rsp_valid_o)
		else $error("reply in listen-only");
	AST_RESTART: assert property (@(posedge clk_i) disable iff (rst_i)
		comm_restart_o |-> !listen_only_o)
		else $error("restart left listen-only");
	AST_ECHO: assert property (@(posedge clk_i) disable iff (rst_i)
		go && is_diag && req_r.addr == 16'h0000 && !exc |=> rsp_r.data == $past(req_r.data))
		else $error("loop-back data differs");
	AST_DELIM: assert property (@(posedge clk_i) disable iff (rst_i)
		go && is_diag && req_r.addr == 16'h0003 && !exc |=> delim_o == $past(req_r.data[15:8]))
		else $error("delimiter not replaced");
	AST_DISC: assert property (@(posedge clk_i) disable iff (rst_i)
		disc_w == {ch_range_err_i, ch_active_i})
		else $error("discrete input map wrong");

	// ----------------------------------------
	// checks: answers and side effects
	// ----------------------------------------
	AST_LSN_ENTER: assert property (@(posedge clk_i) disable iff (rst_i)
		go && enter_listen |=> listen_only_o && !rsp_valid_o)
		else $error("listen-only command was answered");
	AST_LSN_QUIET: assert property (@(posedge clk_i) disable iff (rst_i)
		go && listen_r |=> state_r == ssrh_pkg::SSRH_IDLE)
		else $error("send state reached in listen-only");
	AST_RST_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
		go && !exc && is_diag && req_r.addr == `SSRH_SUB_RESTART |=> comm_restart_o && !listen_only_o)
		else $error("restart did not pulse");
	AST_DIAGREG: assert property (@(posedge clk_i) disable iff (rst_i)
		go && !exc && is_diag && req_r.addr == `SSRH_SUB_DIAGREG |=> rsp_r.data == $past(diag_reg_i))
		else $error("diagnostic register not returned");
	AST_FC11: assert property (@(posedge clk_i) disable iff (rst_i)
		go && fc == 8'h0B |=> rsp_r.exc && rsp_r.code == `SSRH_EX_FUNC)
		else $error("event counter fetch not refused");
	AST_COIL_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
		go && !exc && is_wr_coil |=> coils_o[req_r.addr[4:0]] == (req_r.data == `SSRH_COIL_ON))
		else $error("single coil not forced");
	AST_HOLD_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
		go && !exc && is_wr_reg |=> hold_o[req_r.addr[6:0]] == req_r.data)
		else $error("single register not preset");
	AST_NO_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
		go && exc |=> $stable(coils_o) && $stable(delim_o))
		else $error("refused request changed state");
	AST_REFUSE_IN: assert property (@(posedge clk_i) disable iff (rst_i)
		go && fc == `SSRH_FC_RD_INREG && !is_input_i |=> rsp_r.exc)
		else $error("output module served input registers");
	AST_EXC_CODE: assert property (@(posedge clk_i) disable iff (rst_i)
		go && exc |=> rsp_r.code == $past(exc_code))
		else $error("exception code not carried");
	AST_OK_RSP: assert property (@(posedge clk_i) disable iff (rst_i)
		go && !exc |=> !rsp_r.exc && rsp_r.func == $past(fc) && rsp_r.code == 8'h00)
		else $error("normal answer malformed");
	AST_STAND: assert property (@(posedge clk_i) disable iff (rst_i)
		rsp_valid_o && !rsp_ready_i |=> rsp_valid_o && $stable(rsp_o))
		else $error("answer dropped before acceptance");

endmodule

// ===== ssrh_master.sv
// bus master stand-in: one request, then collects the answer
`timescale 1ns/1ps
module ssrh_master
(
	// clock
	input  wire logic                clk_i,
	// request side
	output logic                     req_valid_o,
	output ssrh_pkg::ssrh_req_t      req_o,
	input  wire logic                req_ready_i,
	// response side
	input  wire logic                rsp_valid_i,
	input  wire ssrh_pkg::ssrh_rsp_t rsp_i,
	output logic                     rsp_ready_o
);
	// idle levels at time zero
	initial
	begin
		req_valid_o = 1'b0;
		req_o = '0;
		rsp_ready_o = 1'b0;
	end
	// stall holds off acceptance so the answer must stand
	task automatic xfer(input ssrh_pkg::ssrh_req_t q, input int stall, output ssrh_pkg::ssrh_rsp_t r,
		output logic got);
		int n;
		got = 1'b0;
		req_valid_o <= 1'b1;
		req_o <= q;
		for (n = 0; n < 8; n++)
		begin
			@(posedge clk_i);
			if (req_ready_i)
				break;
		end
		req_valid_o <= 1'b0;
		req_o <= ~q; // released fields change so stale data never looks valid
		for (n = 0; n < 6; n++)
		begin
			@(posedge clk_i);
			if (rsp_valid_i)
			begin
				got = 1'b1;
				r = rsp_i;
				break;
			end
		end
		if (got)
		begin
			repeat (stall) @(posedge clk_i);
			rsp_ready_o <= 1'b1;
			@(posedge clk_i);
			rsp_ready_o <= 1'b0;
		end
	endtask
endmodule

// ===== ssrh_core_bench.sv
// self-checking bench for the request interpreter
`timescale 1ns/1ps
module ssrh_core_bench;
	logic clk, rst, is_in, rv, rr, rsv, rbit, lst, rstp, seen, rsp_rdy;
	logic [6:0] ridx;
	logic [15:0] wword, act, rerr, dreg, rword;
	logic [15:0] aint [16];
	logic [31:0] aflt [16];
	logic [15:0] hold [112];
	logic [31:0] coils;
	logic [7:0] delim;
	ssrh_pkg::ssrh_req_t rq;
	ssrh_pkg::ssrh_rsp_t rsp, rso;
	logic got;
	int err_count, num_checks;
	ssrh_core u_dut (.clk_i(clk), .rst_i(rst), .is_input_i(is_in), .req_valid_i(rv), .req_i(rq),
		.req_ready_o(rr), .wr_word_i(wword), .wr_idx_o_unused_i(7'h00), .rsp_valid_o(rsv), .rsp_o(rso),
		.rsp_ready_i(rsp_rdy), .rd_idx_i(ridx), .rd_word_o(rword), .rd_bit_o(rbit), .ch_active_i(act),
		.ch_range_err_i(rerr), .ain_int_i(aint), .ain_flt_i(aflt), .coils_o(coils), .hold_o(hold),
		.delim_o(delim), .listen_only_o(lst), .comm_restart_o(rstp), .diag_reg_i(dreg));
	ssrh_master u_mst (.clk_i(clk), .req_valid_o(rv), .req_o(rq), .req_ready_i(rr), .rsp_valid_i(rsv),
		.rsp_i(rso), .rsp_ready_o(rsp_rdy));
	// clock and time-zero input values
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial
	begin
		{rst, is_in, ridx, wword, act, rerr, dreg} = '0;
		for (int i = 0; i < 16; i++)
		begin
			aint[i] = 16'h0100 + 16'(i);
			aflt[i] = {16'hC000 + 16'(i), 16'h0200 + 16'(i)};
		end
	end
	// restart is a one-cycle pulse, so latch it
	always @(posedge clk)
		seen <= rst ? 1'b0 : (seen | rstp);
	task automatic chk(input logic ok, input string m);
		num_checks++;
		if (ok !== 1'b1)
		begin
			err_count++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask
	// one request; code 00 means a normal answer
	task automatic run(input logic [7:0] f, input logic [15:0] a, q, d, input logic [7:0] c);
		u_mst.xfer('{func:f, addr:a, qty:q, data:d}, f[0] ? 0 : 3, rsp, got);
		chk(got === 1'b1, "no response");
		chk(rsp.exc === (c != 8'h00), "exception flag");
		chk(rsp.func === ((c != 8'h00) ? (f | 8'h80) : f), "function echo");
		if (c != 8'h00)
			chk(rsp.code === c, "exception code");
	endtask
	task automatic t_reads();
		run(8'h01, 16'h0000, 16'h0020, 16'h0000, 8'h00);
		run(8'h03, 16'h0030, 16'h0040, 16'h0000, 8'h00);
		run(8'h04, 16'h0000, 16'h0030, 16'h0000, 8'h00);
		ridx <= 7'h03;
		repeat (2) @(posedge clk);
		chk(rword === 16'h0103, "int input word");
		ridx <= 7'h12;
		repeat (2) @(posedge clk);
		chk(rword === 16'hC001, "float high word");
	endtask
	task automatic t_status();
		act <= 16'h8001;
		rerr <= 16'h0006;
		@(posedge clk);
		run(8'h02, 16'h0000, 16'h0020, 16'h0000, 8'h00);
		for (int i = 0; i < 32; i++)
		begin
			ridx <= 7'(i);
			repeat (2) @(posedge clk);
			chk(rbit === ((i < 16) ? act[i] : rerr[i - 16]), "status bit");
		end
	endtask
	task automatic t_writes();
		run(8'h05, 16'h0011, 16'h0001, 16'hFF00, 8'h00);
		chk(coils[17] === 1'b1, "single coil");
		wword <= 16'hA5A5;
		run(8'h0F, 16'h0000, 16'h0010, 16'h0000, 8'h00);
		chk(coils[15:0] === 16'hA5A5, "coil group");
		run(8'h06, 16'h0030, 16'h0001, 16'h4321, 8'h00);
		chk(hold[48] === 16'h4321, "single preset");
		run(8'h03, 16'h0030, 16'h0001, 16'h0000, 8'h00);
		ridx <= 7'h30;
		repeat (2) @(posedge clk);
		chk(rword === 16'h4321, "holding read-back");
		run(8'h10, 16'h0032, 16'h0001, 16'h0000, 8'h00);
		chk(hold[50] === 16'hA5A5, "multiple preset");
	endtask
	task automatic t_errors();
		logic [7:0] bad [7] = '{8'h07, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h11, 8'h18};
		foreach (bad[i])
			run(bad[i], 16'h0000, 16'h0001, 16'h0000, 8'h01);
		run(8'h04, 16'h0030, 16'h0001, 16'h0000, 8'h02);
		run(8'h02, 16'h001F, 16'h0002, 16'h0000, 8'h02);
		run(8'h03, 16'h0070, 16'h0001, 16'h0000, 8'h02);
		run(8'h06, 16'h0000, 16'h0001, 16'h0001, 8'h02);
		run(8'h05, 16'h0000, 16'h0001, 16'h1234, 8'h03);
		run(8'h03, 16'h0030, 16'h0000, 16'h0000, 8'h03);
		run(8'h08, 16'h0005, 16'h0000, 16'h0000, 8'h01);
	endtask
	task automatic t_output();
		is_in <= 1'b0;
		run(8'h06, 16'h0000, 16'h0001, 16'h2710, 8'h00);
		chk(hold[0] === 16'h2710, "full-scale int");
		run(8'h06, 16'h0000, 16'h0001, 16'h2711, 8'h03);
		run(8'h04, 16'h0000, 16'h0001, 16'h0000, 8'h01);
		is_in <= 1'b1;
	endtask
	task automatic t_diag();
		dreg <= 16'h5A3C;
		run(8'h08, 16'h0000, 16'h0000, 16'hBEEF, 8'h00);
		chk(rsp.data === 16'hBEEF, "loop-back data");
		run(8'h08, 16'h0002, 16'h0000, 16'h0000, 8'h00);
		chk(rsp.data === 16'h5A3C, "diag register");
		chk(delim === 8'h0A, "delimiter reset");
		run(8'h08, 16'h0003, 16'h0000, 16'h3A00, 8'h00);
		chk(delim === 8'h3A, "new delimiter");
		u_mst.xfer('{func:8'h08, addr:16'h0004, qty:16'h0000, data:16'h0000}, 0, rsp, got);
		chk(got === 1'b0 && lst === 1'b1, "listen-only entry");
		u_mst.xfer('{func:8'h04, addr:16'h0000, qty:16'h0001, data:16'h0000}, 0, rsp, got);
		chk(got === 1'b0, "silent in listen-only");
		u_mst.xfer('{func:8'h08, addr:16'h0001, qty:16'h0000, data:16'h0000}, 0, rsp, got);
		chk(lst === 1'b0 && seen === 1'b1, "restart");
		run(8'h08, 16'h0000, 16'h0000, 16'h1234, 8'h00);
		chk(rsp.data === 16'h1234, "reply after restart");
	endtask
	task automatic stop_test();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// main sequence
	initial
	begin
		rst <= 1'b1;
		is_in <= 1'b1;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk(rr === 1'b1 && rsv === 1'b0 && coils === 32'h0 && lst === 1'b0, "reset state");
		t_reads();
		t_status();
		t_writes();
		t_errors();
		t_output();
		t_diag();
		stop_test();
	end
	// watchdog well beyond the few hundred cycles the tests need
	initial
	begin
		#200000;
		err_count++;
		stop_test();
	end
endmodule
